// [rtl/lbs_uart.sv]
// Break and sync character transceiver for a LIN-style serial bus
`timescale 1ns/1ps

module lbs_uart
  import lbs_pkg::*;
(
  input  wire logic                   sys_clk,                // 125 MHz clock
  input  wire logic                   rst_n,                  // Async reset, active low
  input  wire logic                   transmitter_enable,     // Transmitter on
  input  wire logic                   break_request_set,      // Pulse: request a Break
  input  wire logic                   tx_write,               // Pulse: write holding reg
  input  wire logic [lbs_pkg::DATA_W-1:0] tx_holding_register, // Byte written
  input  wire logic                   baud_tick,              // One pulse per bit time
  input  wire logic                   baud_x16_tick,          // Sixteen pulses per bit
  input  wire logic                   rx_line_pin,            // Serial input, async
  input  wire logic                   auto_wake_enable,       // Wake on Break mode
  input  wire logic [1:0]             rx_out_select,          // Receive-line output source
  input  wire logic                   alarm_pulse,            // Alarm pulse source
  input  wire logic                   seconds_clock,          // Seconds clock source
  output logic                        tx_line,                // Serial output, idle high
  output logic                        break_send_request,     // Break pending or in flight
  output logic                        shift_register_empty,   // High when idle
  output logic                        tx_buffer_empty_flag,   // Holding reg free
  output logic                        rx_byte_flag,           // Pulse: byte or wake seen
  output logic [lbs_pkg::DATA_W-1:0]  rx_data,                // Last received byte
  output logic                        wake_pending,           // Wake armed, until the Break ends
  output logic                        rx_line_out             // Selected alarm/seconds
);
  logic                rst_meta_n, rst_sync_n;
  logic                rx_s1, rx_s2, rx_s3;
  logic                rx_level, next_rx_level;

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      {rst_sync_n, rst_meta_n} <= 2'h0;
    else
      {rst_sync_n, rst_meta_n} <= {rst_meta_n, 1'b1};
  end

  // Line level changes only once stages two and three agree, filtering single glitches
  always_comb
  begin
    next_rx_level = (rx_s2 == rx_s3) ? rx_s3 : rx_level;
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      {rx_s3, rx_s2, rx_s1} <= 3'h7;
      rx_level              <= 1'b1;
    end
    else
    begin
      {rx_s3, rx_s2, rx_s1} <= {rx_s2, rx_s1, rx_line_pin};
      rx_level              <= next_rx_level;
    end
  end

  // Transmit path
  lbs_tx_t             tx_state, next_tx_state;
  logic [DATA_W-1:0]   hold, next_hold, shift, next_shift;
  logic [CNT_W-1:0]    tx_cnt, next_tx_cnt;
  logic                tx_is_break, next_tx_is_break, next_tx_line, buf_free;
  logic                next_break_send_request, next_shift_register_empty;
  logic                next_tx_buffer_empty_flag;

  always_comb
  begin
    next_tx_state             = tx_state;
    next_hold                 = hold;
    next_shift                = shift;
    next_tx_cnt               = tx_cnt;
    next_tx_is_break          = tx_is_break;
    next_tx_line              = tx_line;
    next_break_send_request   = break_send_request;
    buf_free                  = tx_buffer_empty_flag;
    unique case (tx_state)
      LBS_TX_IDLE:
      begin
        next_tx_line = 1'b1;
        // Nothing leaves the buffer while disabled, so a Break request just waits
        if (transmitter_enable && !tx_buffer_empty_flag)
        begin
          next_tx_state    = LBS_TX_START;
          next_tx_line     = 1'b0;
          buf_free         = 1'b1;
          next_tx_is_break = break_send_request;
          next_shift       = break_send_request ? BYTE_ZERO : hold;
          next_tx_cnt      = CNT_ZERO;
        end
      end
      LBS_TX_START:
      begin
        if (baud_tick)
        begin
          next_tx_state = LBS_TX_DATA;
          next_tx_line  = shift[0];
          next_shift    = {1'b0, shift[DATA_W-1:1]};
          next_tx_cnt   = CNT_ONE;
        end
      end
      LBS_TX_DATA:
      begin
        if (baud_tick)
        begin
          // A Break holds the line low for thirteen bit times: the start bit plus twelve zero bits
          if (tx_cnt == (tx_is_break ? BRK_BITS : NORM_BITS))
          begin
            next_tx_state = LBS_TX_STOP;
            next_tx_line  = 1'b1;
          end
          else
          begin
            next_tx_line = tx_is_break ? 1'b0 : shift[0];
            next_shift   = {1'b0, shift[DATA_W-1:1]};
            next_tx_cnt  = tx_cnt + CNT_ONE;
          end
        end
      end
      LBS_TX_STOP:
      begin
        if (baud_tick)
        begin
          next_tx_state = LBS_TX_IDLE;
          if (tx_is_break)
            next_break_send_request = 1'b0;
          next_tx_is_break = 1'b0;
        end
      end
    endcase
    // A set arriving as hardware clears the request wins
    if (break_request_set)
      next_break_send_request = 1'b1;
    // Writes are taken whenever the holding register is free, even mid-Break
    next_tx_buffer_empty_flag = buf_free;
    if (tx_write && buf_free)
    begin
      next_hold                 = tx_holding_register;
      next_tx_buffer_empty_flag = 1'b0;
    end
    next_shift_register_empty = (next_tx_state == LBS_TX_IDLE);
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      tx_state             <= LBS_TX_IDLE;
      hold                 <= BYTE_ZERO;
      shift                <= BYTE_ZERO;
      tx_cnt               <= CNT_ZERO;
      tx_is_break          <= 1'b0;
      tx_line              <= 1'b1;
      break_send_request   <= 1'b0;
      shift_register_empty <= 1'b1;
      tx_buffer_empty_flag <= 1'b1;
    end
    else
    begin
      tx_state             <= next_tx_state;
      hold                 <= next_hold;
      shift                <= next_shift;
      tx_cnt               <= next_tx_cnt;
      tx_is_break          <= next_tx_is_break;
      tx_line              <= next_tx_line;
      break_send_request   <= next_break_send_request;
      shift_register_empty <= next_shift_register_empty;
      tx_buffer_empty_flag <= next_tx_buffer_empty_flag;
    end
  end

  // Receive path with auto-wake on Break
  lbs_rx_t             rx_state, next_rx_state;
  logic [CNT_W-1:0]    ovs, next_ovs, rx_cnt, next_rx_cnt;
  logic [DATA_W-1:0]   rx_shift, next_rx_shift, next_rx_data;
  logic                next_rx_byte_flag, next_wake_pending, next_rx_line_out, mid_bit;

  always_comb
  begin
    next_rx_state     = rx_state;
    next_ovs          = ovs;
    next_rx_cnt       = rx_cnt;
    next_rx_shift     = rx_shift;
    next_rx_data      = rx_data;
    next_rx_byte_flag = 1'b0;
    mid_bit           = baud_x16_tick && (ovs == OVS_MID);
    if (baud_x16_tick)
      next_ovs = ovs + CNT_ONE;
    unique case (rx_state)
      LBS_RX_IDLE:
      begin
        next_ovs = CNT_ZERO;
        if (auto_wake_enable)
          next_rx_state = LBS_RX_WAKE_FALL;
        else if (!rx_level)
          next_rx_state = LBS_RX_START;
      end
      LBS_RX_WAKE_FALL:
      begin
        if (!rx_level)
          next_rx_state = LBS_RX_WAKE_RISE;
        else if (!auto_wake_enable)
          next_rx_state = LBS_RX_IDLE;
      end
      LBS_RX_WAKE_RISE:
      begin
        // Second transition ends the Break; flag it, then take the next byte once auto_wake_enable is low
        if (rx_level)
        begin
          next_rx_state     = LBS_RX_IDLE;
          next_rx_byte_flag = 1'b1;
        end
      end
      LBS_RX_START:
      begin
        if (mid_bit)
        begin
          next_rx_state = rx_level ? LBS_RX_IDLE : LBS_RX_DATA;
          next_rx_cnt   = CNT_ZERO;
        end
      end
      LBS_RX_DATA:
      begin
        if (mid_bit)
        begin
          next_rx_shift = {rx_level, rx_shift[DATA_W-1:1]};
          next_rx_cnt   = rx_cnt + CNT_ONE;
          if (rx_cnt == NORM_BITS - CNT_ONE)
            next_rx_state = LBS_RX_STOP;
        end
      end
      LBS_RX_STOP:
      begin
        if (mid_bit)
        begin
          next_rx_state     = LBS_RX_IDLE;
          next_rx_data      = rx_shift;
          next_rx_byte_flag = 1'b1;
        end
      end
      default:
        next_rx_state = LBS_RX_IDLE;
    endcase
    // Wake rearms while its enable stays high, so software drops it after the flag
    next_wake_pending = (next_rx_state == LBS_RX_WAKE_FALL) ||
                        (next_rx_state == LBS_RX_WAKE_RISE);
    unique case (rx_out_select)
      SEL_ALARM:   next_rx_line_out = alarm_pulse;
      SEL_SECONDS: next_rx_line_out = seconds_clock;
      default:     next_rx_line_out = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      rx_state     <= LBS_RX_IDLE;
      ovs          <= CNT_ZERO;
      rx_cnt       <= CNT_ZERO;
      rx_shift     <= BYTE_ZERO;
      rx_data      <= BYTE_ZERO;
      rx_byte_flag <= 1'b0;
      wake_pending <= 1'b0;
      rx_line_out  <= 1'b0;
    end
    else
    begin
      rx_state     <= next_rx_state;
      ovs          <= next_ovs;
      rx_cnt       <= next_rx_cnt;
      rx_shift     <= next_rx_shift;
      rx_data      <= next_rx_data;
      rx_byte_flag <= next_rx_byte_flag;
      wake_pending <= next_wake_pending;
      rx_line_out  <= next_rx_line_out;
    end
  end
endmodule : lbs_uart

// [rtl/lbs_pkg.sv]
// Constants and types shared by the break and sync transceiver
package lbs_pkg;
  localparam int          DATA_W        = 8;
  localparam int          CNT_W         = 4;
  localparam logic [3:0]  NORM_BITS     = 4'h8;  // Data bits of an ordinary frame
  localparam logic [3:0]  BRK_BITS      = 4'hC;  // Zero bits after the start bit in a Break frame
  localparam logic [3:0]  OVS_LAST      = 4'hF;  // Receive oversampling, 16 ticks a bit
  localparam logic [3:0]  OVS_MID       = 4'h7;  // Sample point within a bit
  localparam logic [1:0]  SEL_ALARM     = 2'h0;  // Receive-line output shows alarm pulse
  localparam logic [1:0]  SEL_SECONDS   = 2'h1;  // Receive-line output shows seconds clock
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [3:0]  CNT_ZERO      = 4'h0;
  localparam logic [3:0]  CNT_ONE       = 4'h1;

  typedef enum logic [1:0] {LBS_TX_IDLE, LBS_TX_START, LBS_TX_DATA, LBS_TX_STOP} lbs_tx_t;
  typedef enum logic [2:0] {LBS_RX_IDLE, LBS_RX_WAKE_FALL, LBS_RX_WAKE_RISE, LBS_RX_START,
                            LBS_RX_DATA, LBS_RX_STOP} lbs_rx_t;
endpackage : lbs_pkg

// [dv/lbs_uart_asserts.sv]
// Port-level assertion checker for the break and sync transceiver
`timescale 1ns/1ps
module lbs_uart_asserts
  import lbs_pkg::*;
(
  input wire logic       sys_clk,              // Clock
  input wire logic       rst_n,                // Reset, active low
  input wire logic       transmitter_enable,   // Tx on
  input wire logic       tx_write,             // Write pulse
  input wire logic       baud_tick,            // Bit tick
  input wire logic       auto_wake_enable,     // Wake mode
  input wire logic [1:0] rx_out_select,        // Output source
  input wire logic       alarm_pulse,          // Alarm source
  input wire logic       seconds_clock,        // Seconds source
  input wire logic       tx_line,              // Serial out
  input wire logic       break_send_request,   // Break pending
  input wire logic       shift_register_empty, // Tx idle
  input wire logic       tx_buffer_empty_flag, // Holding free
  input wire logic       rx_byte_flag,         // Rx pulse
  input wire logic       wake_pending,         // Wake armed
  input wire logic       rx_line_out           // Selected output
);
  logic [1:0] up;
  logic [1:0] next_up;
  logic [3:0] low_ticks;
  logic [3:0] next_low_ticks;

  // Internal reset trails the pin by two flops, so checks wait for it
  always_comb
  begin
    next_up = (up == 2'h3) ? up : up + 2'h1;
    next_low_ticks = tx_line ? 4'h0 : low_ticks + {3'h0, baud_tick};
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      up <= 2'h0;
      low_ticks <= 4'h0;
    end
    else
    begin
      up <= next_up;
      low_ticks <= next_low_ticks;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n || up != 2'h3);

  sequence s_load;
    !tx_buffer_empty_flag && shift_register_empty && transmitter_enable;
  endsequence
  sequence s_start;
    !tx_line && tx_buffer_empty_flag && !shift_register_empty;
  endsequence

  AST_BRK_LEN: assert property ($rose(tx_line) && break_send_request |-> low_ticks == 4'hD)
    else $error("break low run is not thirteen bit times");
  AST_BRK_END: assert property ($fell(break_send_request) |-> tx_line && $past(baud_tick))
    else $error("break request cleared away from the stop bit end");
  AST_START: assert property ($fell(shift_register_empty) |-> !tx_line)
    else $error("busy without a start bit");
  AST_SRE_IDLE: assert property (shift_register_empty |-> tx_line)
    else $error("idle transmitter with low line");
  AST_NO_TX_OFF: assert property (!transmitter_enable && shift_register_empty
    |=> shift_register_empty && tx_line)
    else $error("activity while transmitter disabled");
  AST_WRITE: assert property (tx_write && tx_buffer_empty_flag |=> !tx_buffer_empty_flag)
    else $error("write not taken into holding register");
  AST_LOAD: assert property (s_load |=> s_start)
    else $error("held byte not loaded when idle");
  AST_WAKE: assert property ($fell(wake_pending) && auto_wake_enable
    |-> ##[0:1] rx_byte_flag)
    else $error("wake end without receive flag");
  AST_SEL_ALARM: assert property (rx_out_select == SEL_ALARM
    |=> rx_line_out == $past(alarm_pulse))
    else $error("alarm selection wrong");
  AST_SEL_SEC: assert property (rx_out_select == SEL_SECONDS
    |=> rx_line_out == $past(seconds_clock))
    else $error("seconds selection wrong");
endmodule : lbs_uart_asserts

bind lbs_uart lbs_uart_asserts i_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .transmitter_enable(transmitter_enable), .tx_write(tx_write), .baud_tick(baud_tick),
  .auto_wake_enable(auto_wake_enable), .rx_out_select(rx_out_select),
  .alarm_pulse(alarm_pulse), .seconds_clock(seconds_clock), .tx_line(tx_line),
  .break_send_request(break_send_request), .shift_register_empty(shift_register_empty),
  .tx_buffer_empty_flag(tx_buffer_empty_flag), .rx_byte_flag(rx_byte_flag),
  .wake_pending(wake_pending), .rx_line_out(rx_line_out));

// [dv/lbs_node_model.sv]
// Behavioural model of another node driving the serial bus
`timescale 1ns/1ps
module lbs_node_model
(
  input  wire logic sys_clk, // Clock
  output logic      line     // Bus toward the device, pulled high when released
);
  localparam int BIT_CYC = 16; // Matches sixteen oversample ticks a bit

  initial line = 1'b1;

  task automatic hold(input logic v, input int bits);
    @(posedge sys_clk);
    line <= v;
    repeat (bits * BIT_CYC - 1) @(posedge sys_clk);
  endtask : hold

  task automatic send_byte(input logic [7:0] b);
    int i;
    hold(1'b0, 1);
    for (i = 0; i < 8; i++) hold(b[i], 1);
    hold(1'b1, 2);
  endtask : send_byte

  // Thirteen low bit times, then released back to the pull-up
  task automatic send_break;
    hold(1'b0, 13);
    hold(1'b1, 2);
  endtask : send_break
endmodule : lbs_node_model

// [dv/lbs_uart_test.sv]
// Self-checking testbench for the break and sync transceiver
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("wrong value %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module lbs_uart_test;
  import lbs_pkg::*;
  typedef struct {logic [7:0] data; logic [15:0] frame;} lbs_row_t;
  logic sys_clk, rst_n, transmitter_enable, break_request_set, tx_write, baud_tick;
  logic baud_x16_tick, auto_wake_enable, alarm_pulse, seconds_clock, rx_line_pin;
  logic tx_line, break_send_request, shift_register_empty, tx_buffer_empty_flag;
  logic rx_byte_flag, wake_pending, rx_line_out;
  logic [1:0] rx_out_select;
  logic [3:0] div = 4'h0;
  logic slow_rx = 1'b0;
  int phase = 0;
  logic [7:0] tx_holding_register, rx_data, last_rx;
  logic [15:0] bits;
  int error_cnt, num_checks, flag_cnt, i, s;
  lbs_row_t rows [4] = '{'{8'h00, 16'h0200}, '{8'hFF, 16'h03FE}, '{8'hA5, 16'h034A},
                         '{8'h55, 16'h02AA}};

  lbs_uart i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .transmitter_enable(transmitter_enable),
    .break_request_set(break_request_set), .tx_write(tx_write),
    .tx_holding_register(tx_holding_register), .baud_tick(baud_tick),
    .baud_x16_tick(baud_x16_tick), .rx_line_pin(rx_line_pin),
    .auto_wake_enable(auto_wake_enable), .rx_out_select(rx_out_select),
    .alarm_pulse(alarm_pulse), .seconds_clock(seconds_clock), .tx_line(tx_line),
    .break_send_request(break_send_request), .shift_register_empty(shift_register_empty),
    .tx_buffer_empty_flag(tx_buffer_empty_flag), .rx_byte_flag(rx_byte_flag),
    .rx_data(rx_data), .wake_pending(wake_pending), .rx_line_out(rx_line_out));
  lbs_node_model i_node (.sys_clk(sys_clk), .line(rx_line_pin));

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Transmit bit time is sixteen clocks
  always @(posedge sys_clk)
  begin
    div <= div + 4'h1;
    baud_tick <= (div == 4'hE);
  end

  // Reduced receive rate for the second Break method: nine ticks in every thirteen clocks
  always @(posedge sys_clk)
  begin
    phase <= (phase == 12) ? 0 : phase + 1;
    baud_x16_tick <= !slow_rx || (phase < 9);
  end

  always @(negedge sys_clk)
    if (rx_byte_flag === 1'b1)
    begin
      flag_cnt++;
      last_rx = rx_data;
    end

  task automatic wr(input logic [7:0] b);
    @(posedge sys_clk);
    tx_write <= 1'b1;
    tx_holding_register <= b;
    @(posedge sys_clk);
    tx_write <= 1'b0;
  endtask : wr

  // Value of each bit is taken at the tick that ends it
  task automatic grab(input int n, output logic [15:0] b);
    int k;
    b = '0;
    for (k = 0; k < 3000 && tx_line !== 1'b0; k++) @(negedge sys_clk);
    for (k = 0; k < n; k++)
    begin
      while (baud_tick !== 1'b1) @(negedge sys_clk);
      b[k] = tx_line;
      @(negedge sys_clk);
    end
  endtask : grab

  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  initial
  begin
    repeat (30000) @(posedge sys_clk);
    error_cnt++;
    end_sim();
  end

  initial
  begin
    {rst_n, transmitter_enable, break_request_set, tx_write} = '0;
    {auto_wake_enable, alarm_pulse, seconds_clock, rx_out_select} = '0;
    {error_cnt, num_checks, flag_cnt} = '0;
    tx_holding_register = 8'h00;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK("idle line", 1'b1, tx_line)
    transmitter_enable <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      wr(rows[i].data);
      grab(10, bits);
      `CHK("frame", rows[i].frame, bits)
      i_node.send_byte(rows[i].data);
      `CHK("rx byte", rows[i].data, last_rx)
    end
    @(posedge sys_clk);
    transmitter_enable <= 1'b0;
    @(posedge sys_clk);
    break_request_set <= 1'b1;
    @(posedge sys_clk);
    break_request_set <= 1'b0;
    wr(8'hFF);
    repeat (40) @(posedge sys_clk);
    `CHK("held idle", 1'b1, shift_register_empty)
    `CHK("held request", 1'b1, break_send_request)
    transmitter_enable <= 1'b1;
    fork
      grab(14, bits);
      begin
        for (s = 0; s < 400 && tx_buffer_empty_flag !== 1'b1; s++) @(negedge sys_clk);
        wr(8'h55);
        wr(8'h00);
        `CHK("busy in break", 1'b0, shift_register_empty)
      end
    join
    `CHK("break frame", 16'h2000, bits)
    grab(10, bits);
    `CHK("sync frame", 16'h02AA, bits)
    `CHK("request cleared", 1'b0, break_send_request)
    repeat (20) @(posedge sys_clk);
    `CHK("idle after", 1'b1, shift_register_empty)
    `CHK("buffer free", 1'b1, tx_buffer_empty_flag)
    auto_wake_enable <= 1'b1;
    repeat (4) @(posedge sys_clk);
    `CHK("wake armed", 1'b1, wake_pending)
    flag_cnt = 0;
    i_node.send_break();
    // Enable is a level, so the receiver rearms until software drops it
    auto_wake_enable <= 1'b0;
    repeat (2) @(posedge sys_clk);
    `CHK("wake flag", 1, flag_cnt)
    `CHK("wake done", 1'b0, wake_pending)
    i_node.send_byte(8'h55);
    `CHK("byte flag", 2, flag_cnt)
    `CHK("sync rx", 8'h55, last_rx)
    slow_rx <= 1'b1;
    flag_cnt = 0;
    i_node.send_break();
    `CHK("slow break flag", 1, flag_cnt)
    `CHK("slow break byte", 8'h00, last_rx)
    slow_rx <= 1'b0;
    for (s = 0; s < 8; s++)
    begin
      @(posedge sys_clk);
      rx_out_select <= s[1:0];
      alarm_pulse <= ~s[2];
      seconds_clock <= s[2];
      repeat (2) @(negedge sys_clk);
      `CHK("line out", (s[1:0] == 2'h0) ? ~s[2] : (s[1:0] == 2'h1) & s[2], rx_line_out)
    end
    end_sim();
  end
endmodule : lbs_uart_test
